// >>> inc/rtcc_defines.svh
// Offsets, field positions and counts of the timer control block.
// Assumes a 32-bit APB with byte strobes; one clock, pclk.
// Function
// - Registers take atomic 8, 16 and 32 bit accesses to their width.
// - Each byte of the 16-bit control register is writable alone.
// - Enable-protected fields change only while the timer is off.
// - Tick clock is source clock over 2**code for codes 0-10 only.
// - Mode 0 is 32-bit count, 1 is 16-bit count, 2 is calendar.
// - With clear-on-match set, a compare 0 match clears the counter.
// - Clear-on-match acts in modes 0 and 2 and never in mode 1.
// - An enable write reads back at once and raises sync pending.
// - Enable takes effect after a sync delay; reads show the target.
// - Enable and soft reset bits are writable in any state; the design drops control writes while a soft reset is busy.
// - Soft reset returns all but debug control to reset and disables; the design then sets the soft reset interrupt flag.
// - A write carrying soft reset discards its other field updates.
// - Soft reset reads one while busy; it and pending clear at the end.
// - Writing zero to the soft reset bit does nothing.
// - Writes to write-protected registers fail while the guard is on.
// - Clear-on-match is writable only while the timer is off.
`ifndef RTCC_DEFINES_SVH
`define RTCC_DEFINES_SVH
`define RTCC_OFS_CTRL     8'h00
`define RTCC_OFS_STATUS   8'h04
`define RTCC_OFS_IRQ_ST   8'h08
`define RTCC_OFS_IRQ_CLR  8'h0c
`define RTCC_OFS_IRQ_EN   8'h10
`define RTCC_OFS_DEBUG    8'h14
`define RTCC_BIT_SOFT_RESET_REQUEST    0
`define RTCC_BIT_ENABLE   1
`define RTCC_BIT_CLEAR_ON_COMPARE_MATCH 7
`define RTCC_BIT_DBG      0
`define RTCC_FLD_PRESC    11:8
`define RTCC_FLD_MODE     3:2
`define RTCC_FLD_IRQ      2:0
`define RTCC_MODE_RSVD    2'h3
`define RTCC_PRESC_MAX    4'ha
`define RTCC_MODE_WIDE    2'h0
`define RTCC_MODE_HALF    2'h1
`define RTCC_MODE_CAL     2'h2
`define RTCC_EV_SYNC      0
`define RTCC_EV_MATCH     1
`define RTCC_EV_SOFT_RESET_REQUEST     2
`define RTCC_SYNC_CYCLES  4
`endif

// >>> inc/rtcc_pkg.sv
// Types shared by the timer control block and its bench.
// Assumes the defines header is compiled alongside.
package rtcc_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } rtcc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rtcc_apb_rsp_t;
  typedef struct packed {
    logic [3:0] presc;
    logic       clear_on_compare_match;
    logic [1:0] mode;
    logic       enable;
  } rtcc_ctrl_t;
  typedef enum logic [1:0] {RTCC_SY_IDLE, RTCC_SY_EN, RTCC_SY_RST} rtcc_sync_t;
  typedef struct packed {
    rtcc_ctrl_t  ctrl;
    rtcc_sync_t  sync;
    logic [7:0]  sync_cnt;
    logic        active;
    logic        dbg;
    logic [2:0]  irq_st;
    logic [2:0]  irq_en;
    logic        gclk_s1;
    logic        gclk_s2;
    logic        gclk_s3;
    logic [9:0]  div_cnt;
    logic        tick;
    logic        clr;
    logic        soft_reset_request_pulse;
    logic [31:0] prdata;
  } rtcc_state_t;
endpackage

// >>> rtl/rtcc_ctrl.sv
// Control register logic of the real-time counter with APB slave.
// Assumes the counter datapath on pclk; source clock arrives unsynced.
`timescale 1ns/1ps
`include "rtcc_defines.svh"
module rtcc_ctrl #(
  parameter int SYNC_CYCLES = `RTCC_SYNC_CYCLES
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB
  input  wire rtcc_pkg::rtcc_apb_req_t apb_req,
  output      rtcc_pkg::rtcc_apb_rsp_t apb_rsp,
  // Access guard and counter side
  input  wire logic                  write_guard_on,
  input  wire logic                  source_generic_clock,
  input  wire logic                  compare0_match,
  output      logic                  counter_tick_clock,
  output      logic                  counter_clear,
  output      logic                  timer_active,
  output      logic                  wide_counter_mode,
  output      logic                  half_counter_mode,
  output      logic                  calendar_mode,
  output      logic                  soft_reset_pulse,
  output      logic                  debug_run_control,
  // Interrupt
  output      logic                  irq
);
  import rtcc_pkg::*;

  localparam int SYNC_BOUND = SYNC_CYCLES + 1;

  rtcc_state_t st;
  rtcc_state_t next_st;

  logic        setup;
  logic        access;
  logic [7:0]  ofs;
  logic        mapped;
  logic        ctrl_wr;
  logic        guard_err;
  logic        wr_ok;
  logic        unlocked;
  logic        soft_reset_request_req;
  logic [15:0] ctrl_rd;
  logic [31:0] rd_mux;
  logic [9:0]  div_mask;
  logic        gclk_rise;
  logic [2:0]  events;
  logic [1:0]  new_mode;

  assign setup  = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign ofs    = {apb_req.paddr[7:2], 2'b00};
  assign mapped = (ofs == `RTCC_OFS_CTRL) || (ofs == `RTCC_OFS_STATUS) ||
                  (ofs == `RTCC_OFS_IRQ_ST) || (ofs == `RTCC_OFS_IRQ_CLR) ||
                  (ofs == `RTCC_OFS_IRQ_EN) || (ofs == `RTCC_OFS_DEBUG);
  assign ctrl_wr   = access & apb_req.pwrite & (ofs == `RTCC_OFS_CTRL);
  assign guard_err = ctrl_wr & write_guard_on;
  assign wr_ok     = access & apb_req.pwrite & mapped & ~guard_err;
  // Judged on the state before the write, so disabling and
  // reconfiguring in one write is refused for the fields
  assign unlocked  = ~st.ctrl.enable & ~st.active;
  assign soft_reset_request_req = ctrl_wr & ~guard_err & apb_req.pstrb[0] &
                     apb_req.pwdata[`RTCC_BIT_SOFT_RESET_REQUEST];
  assign new_mode  = (apb_req.pstrb[0] & unlocked) ?
                     apb_req.pwdata[`RTCC_FLD_MODE] : st.ctrl.mode;

  // Control read view; bit 7 hidden in 16-bit mode
  always_comb begin
    ctrl_rd = 16'h0000;
    ctrl_rd[`RTCC_FLD_PRESC] = st.ctrl.presc;
    ctrl_rd[`RTCC_BIT_CLEAR_ON_COMPARE_MATCH] = st.ctrl.clear_on_compare_match &
                       (st.ctrl.mode != `RTCC_MODE_HALF);
    ctrl_rd[`RTCC_FLD_MODE] = st.ctrl.mode;
    ctrl_rd[`RTCC_BIT_ENABLE] = st.ctrl.enable;
    ctrl_rd[`RTCC_BIT_SOFT_RESET_REQUEST] = (st.sync == RTCC_SY_RST);
  end

  // Full word always returned; sub-word reads pick their lanes
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ofs)
      `RTCC_OFS_CTRL:   rd_mux = {16'h0000, ctrl_rd};
      `RTCC_OFS_STATUS: rd_mux = {30'h0000_0000, st.active,
                                  st.sync != RTCC_SY_IDLE};
      `RTCC_OFS_IRQ_ST: rd_mux = {29'h0000_0000, st.irq_st};
      `RTCC_OFS_IRQ_EN: rd_mux = {29'h0000_0000, st.irq_en};
      `RTCC_OFS_DEBUG:  rd_mux = {31'h0000_0000, st.dbg};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // Power-of-two divide; reserved codes give no ticks at all
  assign div_mask  = 10'((11'h001 << st.ctrl.presc) - 11'h001);
  assign gclk_rise = st.gclk_s2 & ~st.gclk_s3;

  always_comb begin
    next_st = st;
    events  = 3'b000;
    next_st.tick        = 1'b0;
    next_st.clr         = 1'b0;
    next_st.soft_reset_request_pulse = 1'b0;
    // Source clock synchroniser
    next_st.gclk_s1 = source_generic_clock;
    next_st.gclk_s2 = st.gclk_s1;
    next_st.gclk_s3 = st.gclk_s2;
    if (setup) begin
      next_st.prdata = rd_mux;
    end
    // Control writes, byte lanes honoured
    if (ctrl_wr && !guard_err && st.sync != RTCC_SY_RST) begin
      if (soft_reset_request_req) begin
        next_st.sync     = RTCC_SY_RST;
        next_st.sync_cnt = 8'(SYNC_CYCLES);
      end else begin
        if (apb_req.pstrb[1] && unlocked) begin
          next_st.ctrl.presc = apb_req.pwdata[`RTCC_FLD_PRESC];
        end
        if (apb_req.pstrb[0]) begin
          next_st.ctrl.mode = new_mode;
          if (unlocked && new_mode != `RTCC_MODE_HALF) begin
            next_st.ctrl.clear_on_compare_match =
              apb_req.pwdata[`RTCC_BIT_CLEAR_ON_COMPARE_MATCH];
          end
          next_st.ctrl.enable = apb_req.pwdata[`RTCC_BIT_ENABLE];
          next_st.sync        = RTCC_SY_EN;
          next_st.sync_cnt    = 8'(SYNC_CYCLES);
        end
      end
    end
    // Other registers
    if (wr_ok && ofs == `RTCC_OFS_IRQ_EN && apb_req.pstrb[0]) begin
      next_st.irq_en = apb_req.pwdata[`RTCC_FLD_IRQ];
    end
    if (wr_ok && ofs == `RTCC_OFS_IRQ_CLR && apb_req.pstrb[0]) begin
      next_st.irq_st = st.irq_st & ~apb_req.pwdata[`RTCC_FLD_IRQ];
    end
    if (wr_ok && ofs == `RTCC_OFS_DEBUG && apb_req.pstrb[0]) begin
      next_st.dbg = apb_req.pwdata[`RTCC_BIT_DBG];
    end
    // Sync delay towards the counter domain
    case (st.sync)
      RTCC_SY_IDLE: begin
        // A fresh request keeps its loaded count; idle parks at zero
        if (next_st.sync == RTCC_SY_IDLE) begin
          next_st.sync_cnt = 8'h00;
        end
      end
      RTCC_SY_EN: begin
        if (next_st.sync == RTCC_SY_EN && st.sync_cnt > 8'h01 &&
            next_st.sync_cnt == st.sync_cnt) begin
          next_st.sync_cnt = st.sync_cnt - 8'h01;
        end else if (next_st.sync_cnt == st.sync_cnt) begin
          next_st.active = st.ctrl.enable;
          next_st.sync   = RTCC_SY_IDLE;
          events[`RTCC_EV_SYNC] = 1'b1;
        end
      end
      RTCC_SY_RST: begin
        if (st.sync_cnt > 8'h01) begin
          next_st.sync_cnt = st.sync_cnt - 8'h01;
        end else begin
          // Debug control survives
          next_st.ctrl        = '0;
          next_st.active      = 1'b0;
          next_st.irq_en      = 3'b000;
          next_st.irq_st      = 3'b000;
          next_st.sync        = RTCC_SY_IDLE;
          next_st.sync_cnt    = 8'h00;
          next_st.soft_reset_request_pulse = 1'b1;
          events[`RTCC_EV_SOFT_RESET_REQUEST] = 1'b1;
        end
      end
      default: begin
        next_st.sync = RTCC_SY_IDLE;
      end
    endcase
    // Tick divider
    if (!st.active || st.ctrl.presc > `RTCC_PRESC_MAX) begin
      next_st.div_cnt = 10'h000;
    end else if (gclk_rise) begin
      if (st.div_cnt >= div_mask) begin
        next_st.div_cnt = 10'h000;
        next_st.tick    = 1'b1;
      end else begin
        next_st.div_cnt = st.div_cnt + 10'h001;
      end
    end
    // Clear on match, modes 0 and 2 only
    if (compare0_match && st.active) begin
      events[`RTCC_EV_MATCH] = 1'b1;
      next_st.clr = st.ctrl.clear_on_compare_match &&
        (st.ctrl.mode == `RTCC_MODE_WIDE || st.ctrl.mode == `RTCC_MODE_CAL);
    end
    // Set wins over clear
    next_st.irq_st = next_st.irq_st | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Zero wait states; data captured in setup so it is a flop
  assign apb_rsp.prdata  = st.prdata;
  assign apb_rsp.pready  = access;
  assign apb_rsp.pslverr = access & (~mapped | guard_err);

  assign counter_tick_clock = st.tick;
  assign counter_clear      = st.clr;
  assign timer_active       = st.active;
  assign wide_counter_mode  = (st.ctrl.mode == `RTCC_MODE_WIDE);
  assign half_counter_mode  = (st.ctrl.mode == `RTCC_MODE_HALF);
  assign calendar_mode      = (st.ctrl.mode == `RTCC_MODE_CAL);
  assign soft_reset_pulse   = st.soft_reset_request_pulse;
  assign debug_run_control  = st.dbg;
  assign irq                = |(st.irq_st & st.irq_en);

  // Checks
  property p_soft_reset_request_discard;
    @(posedge pclk) disable iff (!presetn)
      soft_reset_request_req && st.sync != RTCC_SY_RST |=> $stable(st.ctrl);
  endproperty
  a_soft_reset_request_discard: assert property (p_soft_reset_request_discard)
    else $error("soft reset write changed fields");

  property p_enable_readback;
    @(posedge pclk) disable iff (!presetn)
      ctrl_wr && !guard_err && !soft_reset_request_req && apb_req.pstrb[0] &&
      st.sync != RTCC_SY_RST
      |=> ctrl_rd[1] == $past(apb_req.pwdata[1]) &&
          st.sync == RTCC_SY_EN;
  endproperty
  a_enable_readback: assert property (p_enable_readback)
    else $error("enable not read back or pending not set");

  property p_sync_done;
    @(posedge pclk) disable iff (!presetn)
      $rose(st.sync == RTCC_SY_EN)
      |-> ##[1:SYNC_BOUND] (st.sync != RTCC_SY_EN);
  endproperty
  a_sync_done: assert property (p_sync_done)
    else $error("enable sync never completed");

  property p_active_follows;
    @(posedge pclk) disable iff (!presetn)
      $past(st.sync) == RTCC_SY_EN && st.sync == RTCC_SY_IDLE
      |-> st.active == st.ctrl.enable;
  endproperty
  a_active_follows: assert property (p_active_follows)
    else $error("active differs from enable after sync");

  property p_enprot;
    @(posedge pclk) disable iff (!presetn)
      ctrl_wr && !soft_reset_request_req && (st.ctrl.enable || st.active) &&
      st.sync != RTCC_SY_RST
      |=> $stable(st.ctrl.presc) && $stable(st.ctrl.clear_on_compare_match);
  endproperty
  a_enprot: assert property (p_enprot)
    else $error("protected field written while enabled");

  property p_guard;
    @(posedge pclk) disable iff (!presetn)
      ctrl_wr && write_guard_on && st.sync != RTCC_SY_RST
      |-> apb_rsp.pslverr ##1 $stable(st.ctrl);
  endproperty
  a_guard: assert property (p_guard)
    else $error("guarded write not blocked");

  property p_soft_reset_request_busy;
    @(posedge pclk) disable iff (!presetn)
      st.sync == RTCC_SY_RST |-> ctrl_rd[`RTCC_BIT_SOFT_RESET_REQUEST] &&
      ((ofs != `RTCC_OFS_CTRL && ofs != `RTCC_OFS_STATUS) || rd_mux[0]);
  endproperty
  a_soft_reset_request_busy: assert property (p_soft_reset_request_busy)
    else $error("soft reset busy not visible");

  property p_soft_reset_request_end;
    @(posedge pclk) disable iff (!presetn)
      $rose(st.sync == RTCC_SY_RST)
      |-> ##[1:SYNC_BOUND] (st.ctrl == '0 && !st.active && st.soft_reset_request_pulse);
  endproperty
  a_soft_reset_request_end: assert property (p_soft_reset_request_end)
    else $error("soft reset did not clear control");

  property p_zero_soft_reset_request;
    @(posedge pclk) disable iff (!presetn)
      ctrl_wr && apb_req.pstrb[0] && !apb_req.pwdata[0] &&
      st.sync != RTCC_SY_RST |=> st.sync != RTCC_SY_RST;
  endproperty
  a_zero_soft_reset_request: assert property (p_zero_soft_reset_request)
    else $error("zero write started a reset");

  property p_half_noclr;
    @(posedge pclk) disable iff (!presetn)
      compare0_match && st.ctrl.mode == `RTCC_MODE_HALF |=> !counter_clear;
  endproperty
  a_half_noclr: assert property (p_half_noclr)
    else $error("clear on match acted in 16-bit mode");

  property p_wide_clr;
    @(posedge pclk) disable iff (!presetn)
      compare0_match && st.active && st.ctrl.clear_on_compare_match &&
      st.ctrl.mode == `RTCC_MODE_WIDE |=> counter_clear;
  endproperty
  a_wide_clr: assert property (p_wide_clr)
    else $error("match did not clear counter");

  property p_bit7_hidden;
    @(posedge pclk) disable iff (!presetn)
      half_counter_mode |-> !ctrl_rd[`RTCC_BIT_CLEAR_ON_COMPARE_MATCH];
  endproperty
  a_bit7_hidden: assert property (p_bit7_hidden)
    else $error("bit 7 visible in 16-bit mode");

  property p_tick_legal;
    @(posedge pclk) disable iff (!presetn)
      counter_tick_clock |-> $past(st.active) &&
      $past(st.ctrl.presc) <= `RTCC_PRESC_MAX;
  endproperty
  a_tick_legal: assert property (p_tick_legal)
    else $error("tick with reserved code or disabled");

  property p_lane_hi;
    @(posedge pclk) disable iff (!presetn)
      ctrl_wr && apb_req.pstrb == 4'h2 && st.sync == RTCC_SY_IDLE
      |=> $stable(st.ctrl.enable) && $stable(st.ctrl.mode);
  endproperty
  a_lane_hi: assert property (p_lane_hi)
    else $error("upper byte write touched lower byte");

  // Full count on entry is what makes the delay real
  property p_sync_load;
    @(posedge pclk) disable iff (!presetn)
      $rose(st.sync != RTCC_SY_IDLE) |-> st.sync_cnt == 8'(SYNC_CYCLES);
  endproperty
  a_sync_load: assert property (p_sync_load)
    else $error("sync delay not loaded");

  property p_soft_reset_request_load;
    @(posedge pclk) disable iff (!presetn)
      $rose(st.sync == RTCC_SY_RST) |-> st.sync_cnt == 8'(SYNC_CYCLES);
  endproperty
  a_soft_reset_request_load: assert property (p_soft_reset_request_load)
    else $error("soft reset delay not loaded");

  property p_dbg_kept;
    @(posedge pclk) disable iff (!presetn)
      st.sync == RTCC_SY_RST && !(wr_ok && ofs == `RTCC_OFS_DEBUG)
      |=> $stable(st.dbg);
  endproperty
  a_dbg_kept: assert property (p_dbg_kept)
    else $error("debug control lost in soft reset");

  property p_half_keep;
    @(posedge pclk) disable iff (!presetn)
      ctrl_wr && apb_req.pstrb[0] && new_mode == `RTCC_MODE_HALF &&
      st.sync != RTCC_SY_RST
      |=> $stable(st.ctrl.clear_on_compare_match);
  endproperty
  a_half_keep: assert property (p_half_keep)
    else $error("bit 7 written in 16-bit mode");

  property p_mode_rsvd;
    @(posedge pclk) disable iff (!presetn)
      st.ctrl.mode == `RTCC_MODE_RSVD
      |-> !wide_counter_mode && !half_counter_mode && !calendar_mode;
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd)
    else $error("reserved mode decoded");

  c_enable: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(st.active));
  c_soft_reset_request: cover property (@(posedge pclk) disable iff (!presetn)
    st.soft_reset_request_pulse);
  c_clear: cover property (@(posedge pclk) disable iff (!presetn)
    counter_clear);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule

// >>> sim/rtcc_cpu_model.sv
// Processor side of the control block: an APB master, one call a transfer.
// Assumes calls come from one process, each at a rising edge of pclk.
`timescale 1ns/1ps
module rtcc_cpu_model (
  // Clock and bus
  input  wire logic                    pclk,
  input  wire rtcc_pkg::rtcc_apb_rsp_t apb_rsp,
  output      rtcc_pkg::rtcc_apb_req_t apb_req
);
  import rtcc_pkg::*;
  initial apb_req = '0;
  // Request held until pready seen; strobes pick the lanes
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: d, pstrb: s};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    // Released lines show a fresh pattern, not the old data
    apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a,
                 pwdata: ~d, pstrb: 4'h0};
    @(posedge pclk);
  endtask
endmodule

// >>> sim/rtc_control_register_logic_test.sv
// Self-checking bench of the timer control block.
// Assumes zero wait-state APB and the default sync length of the design.
`timescale 1ns/1ps
module rtc_control_register_logic_test;
  import rtcc_pkg::*;
  localparam int SY = 4;
  logic pclk = 1'b0, presetn = 1'b0, guard = 1'b0, src = 1'b0, cm = 1'b0;
  logic tick, clr, act, wide, half, cal, srp, dbg, irq;
  rtcc_apb_req_t req;
  rtcc_apb_rsp_t rsp;
  logic [33:0] expq[$];
  int mismatches = 0, tests_run = 0, ticks = 0, clrs = 0, srps = 0;
  logic [31:0] seed = 32'h3129984f, v, e;
  rtcc_ctrl #(.SYNC_CYCLES(SY)) u_dut (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .write_guard_on(guard),
    .source_generic_clock(src), .compare0_match(cm),
    .counter_tick_clock(tick), .counter_clear(clr), .timer_active(act),
    .wide_counter_mode(wide), .half_counter_mode(half),
    .calendar_mode(cal), .soft_reset_pulse(srp),
    .debug_run_control(dbg), .irq(irq));
  rtcc_cpu_model u_cpu (.pclk(pclk), .apb_rsp(rsp), .apb_req(req));
  always #2 pclk = ~pclk;
  always begin
    repeat (4) @(posedge pclk);
    src <= ~src;
  end
  always @(posedge pclk) begin
    if (tick === 1'b1) ticks++;
    if (clr === 1'b1) clrs++;
    if (srp === 1'b1) srps++;
  end
  task automatic chk(string n, logic [32:0] s, logic [32:0] x);
    tests_run++;
    if (s !== x) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  // Oldest note taken off whenever a transfer completes
  always @(posedge pclk)
    if (req.psel && req.penable && rsp.pready === 1'b1 && expq.size() > 0) begin
      if (expq[0][33])
        chk("read", {rsp.pslverr, rsp.prdata}, expq[0][32:0]);
      else
        chk("write error", 33'(rsp.pslverr), 33'(expq[0][32]));
      void'(expq.pop_front());
    end
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic er);
    expq.push_back({1'b0, er, 32'h0});
    u_cpu.xfer(1'b1, a, d, s);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] d, logic er);
    expq.push_back({1'b1, er, d});
    u_cpu.xfer(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic pulse_match();
    clrs = 0;
    cm <= 1'b1;
    @(posedge pclk);
    cm <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'h0, 1'b0);
    // Enable with clear-on-match in 32-bit mode while still off
    wr(8'h10, 32'h2, 4'h1, 1'b0);
    wr(8'h00, 32'h82, 4'h1, 1'b0);
    // Pending is only visible for the sync delay, so look first
    rd(8'h04, 32'h1, 1'b0);
    rd(8'h00, 32'h82, 1'b0);
    repeat (SY + 2) @(posedge pclk);
    rd(8'h04, 32'h2, 1'b0);
    chk("active", 33'(act), 33'd1);
    pulse_match();
    chk("clears", 33'(clrs), 33'd1);
    chk("irq", 33'(irq), 33'd1);
    rd(8'h08, 32'h3, 1'b0);
    wr(8'h0c, 32'h2, 4'h1, 1'b0);
    chk("irq masked", 33'(irq), 33'd0);
    // Protected fields refused while on; guard refuses control writes
    wr(8'h00, 32'h0500, 4'h2, 1'b0);
    wr(8'h00, 32'h02, 4'h1, 1'b0);
    rd(8'h00, 32'h82, 1'b0);
    guard <= 1'b1;
    wr(8'h00, 32'h0, 4'h3, 1'b1);
    guard <= 1'b0;
    rd(8'h00, 32'h82, 1'b0);
    wr(8'h00, 32'h80, 4'h1, 1'b0);
    rd(8'h00, 32'h80, 1'b0);
    repeat (SY + 2) @(posedge pclk);
    rd(8'h04, 32'h0, 1'b0);
    // Clear-on-match has no place in 16-bit mode
    wr(8'h00, 32'h84, 4'h1, 1'b0);
    rd(8'h00, 32'h04, 1'b0);
    wr(8'h00, 32'h06, 4'h1, 1'b0);
    repeat (SY + 2) @(posedge pclk);
    pulse_match();
    chk("no clear", 33'(clrs), 33'd0);
    wr(8'h00, 32'h04, 4'h1, 1'b0);
    repeat (SY + 2) @(posedge pclk);
    // Single byte lane, then divide by four
    wr(8'h00, 32'hff0002ff, 4'h2, 1'b0);
    rd(8'h00, 32'h0204, 1'b0);
    wr(8'h00, 32'h02, 4'h1, 1'b0);
    repeat (SY + 2) @(posedge pclk);
    ticks = 0;
    repeat (256) @(posedge pclk);
    chk("ticks", 33'(ticks >= 7 && ticks <= 9), 33'd1);
    wr(8'h00, 32'h0, 4'h1, 1'b0);
    repeat (SY + 2) @(posedge pclk);
    for (int m = 0; m < 4; m++) begin
      v = $random(seed);
      e = {20'h0, 4'(v[11:8] % 11), v[7] & (m != 1), 3'h0, 2'(m), 2'b00};
      wr(8'h00, {v[31:12], e[11:8], v[7:4], 2'(m), 2'b00}, 4'h3, 1'b0);
      rd(8'h00, e, 1'b0);
      chk("modes", {30'h0, wide, half, cal},
          33'({m == 0, m == 1, m == 2}));
    end
    // Soft reset drops the fields it carries and keeps debug control
    wr(8'h14, 32'h1, 4'h1, 1'b0);
    chk("debug", 33'(dbg), 33'd1);
    srps = 0;
    wr(8'h00, 32'h0a0b, 4'h3, 1'b0);
    rd(8'h00, e | 32'h1, 1'b0);
    repeat (SY + 2) @(posedge pclk);
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h04, 32'h0, 1'b0);
    rd(8'h08, 32'h4, 1'b0);
    rd(8'h14, 32'h1, 1'b0);
    chk("debug kept", 33'(dbg), 33'd1);
    chk("reset pulse", 33'(srps), 33'd1);
    wr(8'h00, 32'h0, 4'h2, 1'b0);
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    tally_and_finish();
  end
endmodule
